// ===== sioa_checker.sv
// assertions for the signal allocation block
`timescale 1ns/100ps
`default_nettype none

module sioa_checker (
   // clock and reset
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_I,
   // ahb-lite side
   input  wire logic        HSEL_I,
   input  wire logic [31:0] HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [31:0] HWDATA_I,
   input  wire logic        HREADY_I,
   input  wire logic [31:0] HRDATA_O,
   // shared input, functions and circuits
   input  wire logic        SHARED_IN_CLOSED_I,
   input  wire logic        POS_ERR_CLEAR_O,
   input  wire logic        HOMING_DECEL_O,
   input  wire logic        REG_LATCH_O,
   input  wire logic [20:0] DETECT_I,
   input  wire logic [5:0]  OUT_CIRCUIT_O
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);

   logic        dp_reg;   // data phase pending
   logic        dpw_reg;  // pending phase is a write
   logic [3:0]  dpi_reg;  // register index, f when above the low 64 bytes
   logic [15:0] sh_reg;   // shadow of shared input config
   logic [15:0] il_reg;   // shadow of inversion, low
   logic [15:0] ih_reg;   // shadow of inversion, high
   logic        ld_reg;   // shadow of the loaded bit
   logic [5:0]  inv;      // expected inversion per circuit
   logic        lvl;      // contact level after polarity
   logic [2:0]  fn;       // latch, decel, clear

   ////////////////////////////////////////
   // shadow register writes
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         dp_reg  <= 1'b0;
         dpw_reg <= 1'b0;
         dpi_reg <= 4'h0;
         sh_reg  <= 16'h0000;
         il_reg  <= 16'h0000;
         ih_reg  <= 16'h0000;
         ld_reg  <= 1'b0;
      end else begin
         dp_reg  <= HSEL_I & HTRANS_I[1] & HREADY_I;
         dpw_reg <= HWRITE_I;
         dpi_reg <= (HADDR_I[31:6] == '0) ? HADDR_I[5:2] : 4'hF;
         if (dp_reg && dpw_reg) begin
            case (dpi_reg)
               4'h0: sh_reg <= HWDATA_I[15:0];
               4'h8: il_reg <= HWDATA_I[15:0];
               4'h9: ih_reg <= HWDATA_I[15:0];
               4'hA: ld_reg <= HWDATA_I[0];
               default: ;
            endcase
         end
      end
   end

   assign inv = {ih_reg[7:4] == 4'h1, ih_reg[3:0] == 4'h1, il_reg[15:12] == 4'h1,
                 il_reg[11:8] == 4'h1, il_reg[7:4] == 4'h1, il_reg[3:0] == 4'h1};
   assign lvl = SHARED_IN_CLOSED_I ^ (sh_reg[7:4] == 4'h1);
   assign fn  = {REG_LATCH_O, HOMING_DECEL_O, POS_ERR_CLEAR_O};

   ////////////////////////////////////////
   property p_unloaded;
      !$past(ld_reg) |-> (OUT_CIRCUIT_O == 6'h00) && (fn == 3'b000);
   endproperty
   a_unloaded: assert property (p_unloaded) else $error("output while unloaded");
   property p_one_fn;
      $onehot0(fn);
   endproperty
   a_one_fn: assert property (p_one_fn) else $error("two shared functions");
   property p_sel_none;
      $past(!(sh_reg[3:0] inside {4'h1, 4'h2, 4'h3})) |-> fn == 3'b000;
   endproperty
   a_sel_none: assert property (p_sel_none) else $error("function w/o select");
   property p_clear;
      $past(ld_reg && sh_reg[3:0] == 4'h1) |-> POS_ERR_CLEAR_O == !$past(lvl);
   endproperty
   a_clear: assert property (p_clear) else $error("clear level wrong");
   property p_decel;
      $past(ld_reg && sh_reg[3:0] == 4'h2) |-> HOMING_DECEL_O == $past(lvl);
   endproperty
   a_decel: assert property (p_decel) else $error("decel level wrong");
   property p_latch;
      $past(ld_reg && sh_reg[3:0] == 4'h3) |-> REG_LATCH_O == $past(lvl);
   endproperty
   a_latch: assert property (p_latch) else $error("latch level wrong");
   property p_dark;
      $past(ld_reg && DETECT_I == '0) |-> OUT_CIRCUIT_O == $past(inv);
   endproperty
   a_dark: assert property (p_dark) else $error("undetected status shown");
   property p_rd_ctl;
      dp_reg && !dpw_reg && dpi_reg == 4'hA |-> HRDATA_O == {31'h0000_0000, ld_reg};
   endproperty
   a_rd_ctl: assert property (p_rd_ctl) else $error("loaded bit read wrong");

   c_decel: cover property (HOMING_DECEL_O);
   c_clear: cover property (POS_ERR_CLEAR_O);
   c_lit:   cover property (OUT_CIRCUIT_O != 6'h00);
endmodule // sioa_checker

bind sioa_top sioa_checker u_sioa_checker (
   .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
   .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I),
   .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .SHARED_IN_CLOSED_I(SHARED_IN_CLOSED_I),
   .POS_ERR_CLEAR_O(POS_ERR_CLEAR_O), .HOMING_DECEL_O(HOMING_DECEL_O),
   .REG_LATCH_O(REG_LATCH_O), .DETECT_I(DETECT_I), .OUT_CIRCUIT_O(OUT_CIRCUIT_O));

`default_nettype wire

// ===== sioa_defines.svh
// constants for the servo i/o signal allocation block
`ifndef SIOA_DEFINES_SVH
`define SIOA_DEFINES_SVH

// register byte offsets
`define SIOA_OFS_SHARED_CFG   6'h00
`define SIOA_OFS_GRP_A        6'h04
`define SIOA_OFS_GRP_B        6'h08
`define SIOA_OFS_GRP_C        6'h0C
`define SIOA_OFS_GRP_D        6'h10
`define SIOA_OFS_FAULT_RT     6'h14
`define SIOA_OFS_USER_LO      6'h18
`define SIOA_OFS_USER_HI      6'h1C
`define SIOA_OFS_INV_LO       6'h20
`define SIOA_OFS_INV_HI       6'h24
`define SIOA_OFS_CONTROL      6'h28
`define SIOA_OFS_STATUS       6'h2C

// reset value of every parameter register
`define SIOA_CFG_RESET        16'h0000

// digit positions inside a sixteen-bit parameter
`define SIOA_D0               0
`define SIOA_D1               4
`define SIOA_D2               8
`define SIOA_D3               12

// shared input selection codes and polarity values
`define SIOA_SEL_CLEAR        4'h1
`define SIOA_SEL_DECEL        4'h2
`define SIOA_SEL_LATCH        4'h3
`define SIOA_POL_INVERT       4'h1

// output allocation and inversion values
`define SIOA_ROUTE_OFF        4'h0
`define SIOA_INV_ON           4'h1
`define SIOA_NUM_SIGS         21
`define SIOA_NUM_CIRC         6

// control and status bit positions
`define SIOA_CTL_LOADED       0
`define SIOA_STS_FN_LSB       6
`define SIOA_STS_LOADED       9

`endif

// ===== sioa_field.sv
// field model: contact at the shared terminal pair
`timescale 1ns/100ps
`default_nettype none

module sioa_field (
   // clock
   input  wire logic clk_i,     // system clock
   // command from the bench
   input  wire logic close_i,   // operator closes the contact
   // terminal side
   output var  logic closed_o   // contact state at the pins
);
   initial closed_o = 1'b0;  // contact open at power up

   // contact follows a cycle late, off the command's step
   always @(posedge clk_i) begin
      closed_o <= close_i;
   end
endmodule // sioa_field

`default_nettype wire

// ===== sioa_pkg.sv
// types shared by the servo i/o signal allocation block
package sioa_pkg;

   // configuration load state
   typedef enum logic [0:0] {
      SIOA_CFG_UNLOADED,
      SIOA_CFG_ACTIVE
   } sioa_cfg_e;

   // whole state of the top module
   typedef struct packed {
      sioa_cfg_e   cfg_state;   // parameters loaded or not
      logic [15:0] shared_cfg;  // shared input selection and polarity
      logic [15:0] grp_a;       // routing digits, group a
      logic [15:0] grp_b;       // routing digits, group b
      logic [15:0] grp_c;       // routing digits, group c
      logic [15:0] grp_d;       // routing digits, group d
      logic [15:0] fault_rt;    // fault code bit routing
      logic [15:0] user_lo;     // user output routing, low
      logic [15:0] user_hi;     // user output routing, high
      logic [15:0] inv_lo;      // circuit inversion, low
      logic [15:0] inv_hi;      // circuit inversion, high
      logic        dp_hit;      // data phase pending
      logic        dp_write;    // pending data phase is a write
      logic [3:0]  dp_idx;      // register index of data phase
      logic [31:0] rdata;       // read data for the bus
      logic [2:0]  shared_fn;   // clear, decel, latch outputs
      logic [5:0]  circuit;     // output circuit levels
   } sioa_state_s;

endpackage

// ===== sioa_route.sv
// routing matrix: or of routed signals, then inversion
`timescale 1ns/100ps
`default_nettype none
`include "sioa_defines.svh"

module sioa_route
   import sioa_pkg::*;
(
   // signal side
   input  wire logic [20:0] sig_i,      // internal status, high = on
   input  wire logic [20:0] detect_i,   // status valid in present mode
   input  wire logic [83:0] digit_i,    // four bits per signal
   // circuit side
   input  wire logic [5:0]  invert_i,   // per circuit inversion
   input  wire logic        enable_i,   // parameters loaded
   output logic      [5:0]  circuit_o   // circuit levels, high = on
);

   ////////////////////////////////////////////////////////////////////
   // does a routing digit select circuit k (k counted from zero)
   function automatic logic hits(input logic [3:0] dig, input int k);
      hits = (dig != `SIOA_ROUTE_OFF) && (dig == 4'(k + 1));
   endfunction

   logic [5:0] ored; // combined level per circuit before inversion

   ////////////////////////////////////////////////////////////////////
   // each circuit ors every signal routed to it
   always_comb begin
      ored = 6'b00_0000;
      for (int k = 0; k < `SIOA_NUM_CIRC; k++) begin
         for (int i = 0; i < `SIOA_NUM_SIGS; i++) begin
            // undetected status counts as off
            if (hits(digit_i[i*4 +: 4], k) && detect_i[i] && sig_i[i]) begin
               ored[k] = 1'b1;
            end
         end
      end
   end

   // invert after the or; unloaded keeps all circuits off,
   // so an inverted circuit cannot light at power up
   assign circuit_o = enable_i ? (ored ^ invert_i) : 6'b00_0000;

endmodule // sioa_route

`default_nettype wire

// ===== sioa_top.sv
// servo i/o signal allocation: ahb-lite registers, shared input, outputs
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "sioa_defines.svh"

module sioa_top
   import sioa_pkg::*;
(
   // clock and reset
   input  wire logic        CLK_SYS_I,       // 250 MHz system clock
   input  wire logic        RST_I,           // synchronous, active high
   // ahb-lite slave
   input  wire logic        HSEL_I,          // slave select
   input  wire logic [31:0] HADDR_I,         // byte address
   input  wire logic [1:0]  HTRANS_I,        // transfer type
   input  wire logic        HWRITE_I,        // write when high
   input  wire logic [2:0]  HSIZE_I,         // word transfers only
   input  wire logic [31:0] HWDATA_I,        // write data
   input  wire logic        HREADY_I,        // bus ready
   output logic      [31:0] HRDATA_O,        // read data
   output logic             HREADYOUT_O,     // never stalls
   output logic             HRESP_O,         // always okay
   // shared dedicated input terminal pair
   input  wire logic        SHARED_IN_CLOSED_I,  // contacts closed
   output logic             POS_ERR_CLEAR_O,     // clear function active
   output logic             HOMING_DECEL_O,      // deceleration switch active
   output logic             REG_LATCH_O,         // registration input active
   // internal status signals and their mode validity
   input  wire logic [20:0] STATUS_I,        // status, high = on
   input  wire logic [20:0] DETECT_I,        // detected in present mode
   // output circuits, high = output transistor on
   output logic      [5:0]  OUT_CIRCUIT_O
);

   ////////////////////////////////////////////////////////////////////
   // state and its next value
   sioa_state_s s_reg;        // all registered state
   sioa_state_s s_next;       // next state
   logic [83:0] route_digits; // one routing digit per status signal
   logic [5:0]  invert;       // inversion per circuit
   logic [5:0]  circuit;      // routed circuit levels
   logic        addr_ok;      // address phase selects a valid transfer
   logic        is_mapped;    // address lies in the register map
   logic [3:0]  addr_idx;     // word index of the address
   logic [2:0]  fn_next;      // shared input functions, next value
   logic        level_slash;  // level for functions active on close

   ////////////////////////////////////////////////////////////////////
   // byte offset to register word index
   function automatic logic [3:0] word_idx(input logic [5:0] ofs);
      word_idx = ofs[5:2];
   endfunction

   // read mux over the register map, unmapped words read zero
   function automatic logic [31:0] reg_read(input sioa_state_s st,
                                             input logic [3:0] idx);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (idx == word_idx(`SIOA_OFS_SHARED_CFG)) begin
         v[15:0] = st.shared_cfg;
      end else if (idx == word_idx(`SIOA_OFS_GRP_A)) begin
         v[15:0] = st.grp_a;
      end else if (idx == word_idx(`SIOA_OFS_GRP_B)) begin
         v[15:0] = st.grp_b;
      end else if (idx == word_idx(`SIOA_OFS_GRP_C)) begin
         v[15:0] = st.grp_c;
      end else if (idx == word_idx(`SIOA_OFS_GRP_D)) begin
         v[15:0] = st.grp_d;
      end else if (idx == word_idx(`SIOA_OFS_FAULT_RT)) begin
         v[15:0] = st.fault_rt;
      end else if (idx == word_idx(`SIOA_OFS_USER_LO)) begin
         v[15:0] = st.user_lo;
      end else if (idx == word_idx(`SIOA_OFS_USER_HI)) begin
         v[15:0] = st.user_hi;
      end else if (idx == word_idx(`SIOA_OFS_INV_LO)) begin
         v[15:0] = st.inv_lo;
      end else if (idx == word_idx(`SIOA_OFS_INV_HI)) begin
         v[15:0] = st.inv_hi;
      end else if (idx == word_idx(`SIOA_OFS_CONTROL)) begin
         v[`SIOA_CTL_LOADED] = (st.cfg_state == SIOA_CFG_ACTIVE);
      end else if (idx == word_idx(`SIOA_OFS_STATUS)) begin
         // live view of circuits, shared functions and load state
         v[5:0] = st.circuit;
         v[`SIOA_STS_FN_LSB +: 3] = st.shared_fn;
         v[`SIOA_STS_LOADED] = (st.cfg_state == SIOA_CFG_ACTIVE);
      end
      reg_read = v;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // address phase decode
   assign addr_idx  = HADDR_I[5:2];
   assign is_mapped = (HADDR_I[31:6] == 26'h000_0000) &&
                      (addr_idx <= word_idx(`SIOA_OFS_STATUS));
   assign addr_ok   = HSEL_I && HTRANS_I[1] && HREADY_I;

   ////////////////////////////////////////////////////////////////////
   // gather one routing field per status signal, up to four per parameter
   // with the lowest digit first; unused digits carry no signal
   always_comb begin
      route_digits = '0;
      route_digits[ 0*4 +: 4] = s_reg.grp_a[`SIOA_D0 +: 4];
      route_digits[ 1*4 +: 4] = s_reg.grp_a[`SIOA_D1 +: 4];
      route_digits[ 2*4 +: 4] = s_reg.grp_a[`SIOA_D2 +: 4];
      route_digits[ 3*4 +: 4] = s_reg.grp_a[`SIOA_D3 +: 4];
      route_digits[ 4*4 +: 4] = s_reg.grp_b[`SIOA_D0 +: 4];
      route_digits[ 5*4 +: 4] = s_reg.grp_b[`SIOA_D1 +: 4];
      // brake digit: its logic sense is left
      // to the configurer
      route_digits[ 6*4 +: 4] = s_reg.grp_b[`SIOA_D2 +: 4];
      route_digits[ 7*4 +: 4] = s_reg.grp_b[`SIOA_D3 +: 4];
      route_digits[ 8*4 +: 4] = s_reg.grp_c[`SIOA_D0 +: 4];
      route_digits[ 9*4 +: 4] = s_reg.grp_c[`SIOA_D2 +: 4];
      route_digits[10*4 +: 4] = s_reg.grp_d[`SIOA_D2 +: 4];
      route_digits[11*4 +: 4] = s_reg.fault_rt[`SIOA_D0 +: 4];
      route_digits[12*4 +: 4] = s_reg.fault_rt[`SIOA_D1 +: 4];
      route_digits[13*4 +: 4] = s_reg.fault_rt[`SIOA_D2 +: 4];
      route_digits[14*4 +: 4] = s_reg.user_lo[`SIOA_D0 +: 4];
      route_digits[15*4 +: 4] = s_reg.user_lo[`SIOA_D1 +: 4];
      route_digits[16*4 +: 4] = s_reg.user_lo[`SIOA_D2 +: 4];
      route_digits[17*4 +: 4] = s_reg.user_lo[`SIOA_D3 +: 4];
      route_digits[18*4 +: 4] = s_reg.user_hi[`SIOA_D0 +: 4];
      route_digits[19*4 +: 4] = s_reg.user_hi[`SIOA_D1 +: 4];
      route_digits[20*4 +: 4] = s_reg.user_hi[`SIOA_D2 +: 4];
   end

   ////////////////////////////////////////////////////////////////////
   // one inversion digit per circuit, split over two parameters
   always_comb begin
      invert[0] = (s_reg.inv_lo[`SIOA_D0 +: 4] == `SIOA_INV_ON);
      invert[1] = (s_reg.inv_lo[`SIOA_D1 +: 4] == `SIOA_INV_ON);
      invert[2] = (s_reg.inv_lo[`SIOA_D2 +: 4] == `SIOA_INV_ON);
      invert[3] = (s_reg.inv_lo[`SIOA_D3 +: 4] == `SIOA_INV_ON);
      invert[4] = (s_reg.inv_hi[`SIOA_D0 +: 4] == `SIOA_INV_ON);
      invert[5] = (s_reg.inv_hi[`SIOA_D1 +: 4] == `SIOA_INV_ON);
   end

   ////////////////////////////////////////////////////////////////////
   // routing matrix
   sioa_route u_route (
      .sig_i     (STATUS_I),
      .detect_i  (DETECT_I),
      .digit_i   (route_digits),
      .invert_i  (invert),
      .enable_i  (s_reg.cfg_state == SIOA_CFG_ACTIVE),
      .circuit_o (circuit)
   );

   ////////////////////////////////////////////////////////////////////
   // shared input: at most one function sees the terminal level
   always_comb begin
      // polarity 0: active-low functions assert with the contacts closed
      level_slash = SHARED_IN_CLOSED_I ^
                    (s_reg.shared_cfg[`SIOA_D1 +: 4] == `SIOA_POL_INVERT);
      fn_next = 3'b000;
      if (s_reg.cfg_state == SIOA_CFG_ACTIVE) begin
         case (s_reg.shared_cfg[`SIOA_D0 +: 4])
            // clear has no active-low mark, so it asserts on open contacts at polarity 0
            `SIOA_SEL_CLEAR: fn_next[0] = ~level_slash;
            `SIOA_SEL_DECEL: fn_next[1] = level_slash;
            `SIOA_SEL_LATCH: fn_next[2] = level_slash;
            default:         fn_next    = 3'b000;       // unused code
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // next state: bus data phase, then address phase, then pin outputs
   always_comb begin
      s_next = s_reg;
      // data phase write lands in the named register, low half only
      if (s_reg.dp_hit && s_reg.dp_write) begin
         if (s_reg.dp_idx == word_idx(`SIOA_OFS_SHARED_CFG)) begin
            s_next.shared_cfg = HWDATA_I[15:0];
         end else if (s_reg.dp_idx == word_idx(`SIOA_OFS_GRP_A)) begin
            s_next.grp_a = HWDATA_I[15:0];
         end else if (s_reg.dp_idx == word_idx(`SIOA_OFS_GRP_B)) begin
            s_next.grp_b = HWDATA_I[15:0];
         end else if (s_reg.dp_idx == word_idx(`SIOA_OFS_GRP_C)) begin
            s_next.grp_c = HWDATA_I[15:0];
         end else if (s_reg.dp_idx == word_idx(`SIOA_OFS_GRP_D)) begin
            s_next.grp_d = HWDATA_I[15:0];
         end else if (s_reg.dp_idx == word_idx(`SIOA_OFS_FAULT_RT)) begin
            s_next.fault_rt = HWDATA_I[15:0];
         end else if (s_reg.dp_idx == word_idx(`SIOA_OFS_USER_LO)) begin
            s_next.user_lo = HWDATA_I[15:0];
         end else if (s_reg.dp_idx == word_idx(`SIOA_OFS_USER_HI)) begin
            s_next.user_hi = HWDATA_I[15:0];
         end else if (s_reg.dp_idx == word_idx(`SIOA_OFS_INV_LO)) begin
            s_next.inv_lo = HWDATA_I[15:0];
         end else if (s_reg.dp_idx == word_idx(`SIOA_OFS_INV_HI)) begin
            s_next.inv_hi = HWDATA_I[15:0];
         end else if (s_reg.dp_idx == word_idx(`SIOA_OFS_CONTROL)) begin
            // software marks the parameter set as loaded or withdraws it
            case (s_reg.cfg_state)
               SIOA_CFG_UNLOADED: begin
                  if (HWDATA_I[`SIOA_CTL_LOADED]) begin
                     s_next.cfg_state = SIOA_CFG_ACTIVE;
                  end
               end
               SIOA_CFG_ACTIVE: begin
                  if (!HWDATA_I[`SIOA_CTL_LOADED]) begin
                     s_next.cfg_state = SIOA_CFG_UNLOADED;
                  end
               end
               default: s_next.cfg_state = SIOA_CFG_UNLOADED;
            endcase
         end
      end
      // address phase; reads see post-write values,
      // so a read right after a write gets the new word
      s_next.dp_hit   = addr_ok && is_mapped;
      s_next.dp_write = addr_ok && HWRITE_I;
      s_next.dp_idx   = addr_idx;
      if (addr_ok && !HWRITE_I && is_mapped) begin
         s_next.rdata = reg_read(s_next, addr_idx);
      end else begin
         s_next.rdata = 32'h0000_0000;
      end
      // pin outputs are registered once
      s_next.shared_fn = fn_next;
      s_next.circuit   = circuit;
   end

   ////////////////////////////////////////////////////////////////////
   // state register with synchronous reset
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         s_reg.cfg_state  <= SIOA_CFG_UNLOADED;
         s_reg.shared_cfg <= `SIOA_CFG_RESET;
         s_reg.grp_a      <= `SIOA_CFG_RESET;
         s_reg.grp_b      <= `SIOA_CFG_RESET;
         s_reg.grp_c      <= `SIOA_CFG_RESET;
         s_reg.grp_d      <= `SIOA_CFG_RESET;
         s_reg.fault_rt   <= `SIOA_CFG_RESET;
         s_reg.user_lo    <= `SIOA_CFG_RESET;
         s_reg.user_hi    <= `SIOA_CFG_RESET;
         s_reg.inv_lo     <= `SIOA_CFG_RESET;
         s_reg.inv_hi     <= `SIOA_CFG_RESET;
         s_reg.dp_hit     <= 1'b0;
         s_reg.dp_write   <= 1'b0;
         s_reg.dp_idx     <= 4'h0;
         s_reg.rdata      <= 32'h0000_0000;
         s_reg.shared_fn  <= 3'b000;
         s_reg.circuit    <= 6'b00_0000;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs; no wait states: the read mux sits in the address
   // phase so every access has one data cycle
   assign HRDATA_O        = s_reg.rdata;
   assign HREADYOUT_O     = 1'b1;
   assign HRESP_O         = 1'b0;
   assign POS_ERR_CLEAR_O = s_reg.shared_fn[0];
   assign HOMING_DECEL_O  = s_reg.shared_fn[1];
   assign REG_LATCH_O     = s_reg.shared_fn[2];
   assign OUT_CIRCUIT_O   = s_reg.circuit;

endmodule // sioa_top

`default_nettype wire

// ===== tb.sv
// self-checking bench for the signal allocation block
`timescale 1ns/100ps
`default_nettype none
`include "sioa_defines.svh"

module tb;
   localparam logic [20:0] ALL = 21'h1F_FFFF;  // every status detected
   // register and shift of each route field
   localparam int FOFS [21] = '{4, 4, 4, 4, 8, 8, 8, 8, 12, 12, 16, 20, 20, 20, 24, 24, 24,
      24, 28, 28, 28};
   localparam int FSH [21] = '{0, 4, 8, 12, 0, 4, 8, 12, 0, 8, 8, 0, 4, 8, 0, 4, 8,
      12, 0, 4, 8};

   logic        clk    = 1'b0;            // system clock
   logic        rst    = 1'b1;            // synchronous reset
   logic        hsel   = 1'b0;            // bus select
   logic [31:0] haddr  = 32'h0000_0000;   // bus address
   logic [1:0]  htrans = 2'b00;           // transfer type
   logic        hwrite = 1'b0;            // write strobe
   logic [31:0] hwdata = 32'h0000_0000;   // write data
   logic [31:0] hrdata;                   // read data
   logic        hready;                   // single slave ready
   logic        hresp;                    // response
   logic        close  = 1'b0;            // contact command
   logic        closed;                   // contact at the pins
   logic        clr;                      // clear function
   logic        dec;                      // decel function
   logic        lat;                      // latch function
   logic [20:0] sts    = 21'h00_0000;     // status inputs
   logic [20:0] det    = ALL;             // mode validity
   logic [5:0]  outc;                     // output circuits
   logic [31:0] rv;                       // last read data
   logic        lv;                       // expected contact level
   logic [2:0]  fexp;                     // expected functions
   int          errors = 0;
   int          checks_done = 0;

   always #2 clk = ~clk;  // 250 MHz

   sioa_top u_sioa_top (
      .CLK_SYS_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .SHARED_IN_CLOSED_I(closed), .POS_ERR_CLEAR_O(clr), .HOMING_DECEL_O(dec),
      .REG_LATCH_O(lat), .STATUS_I(sts), .DETECT_I(det), .OUT_CIRCUIT_O(outc));

   sioa_field u_sioa_field (.clk_i(clk), .close_i(close), .closed_o(closed));

   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one single transfer, waits on hready
   task automatic xfer(input logic [5:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {26'h000_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rv = hrdata;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic rd(input logic [5:0] a);
      xfer(a, 1'b0, 32'h0000_0000);
   endtask

   // drive status, let the output register settle
   task automatic apply(input logic [20:0] s, input logic [20:0] d);
      @(posedge clk);
      sts <= s;
      det <= d;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 12; i++) begin
         rd(6'(4 * i));
         chk("reset value", rv, 32'h0000_0000);
      end
      chk("okay", 32'(hresp), 32'h0000_0000);
      // upper half dropped
      for (int i = 0; i < 10; i++) begin
         wr(6'(4 * i), 32'hFFFF_A5C3);
         rd(6'(4 * i));
         chk("param rw", rv, 32'h0000_A5C3);
         wr(6'(4 * i), 32'h0000_0000);
      end
      wr(6'h30, 32'h0000_0001);
      wr(`SIOA_OFS_STATUS, 32'h0000_FFFF);
      rd(6'h30);
      chk("unmapped", rv, 32'h0000_0000);
      rd(`SIOA_OFS_STATUS);
      chk("status ro", rv, 32'h0000_0000);
      // routing stays dark until loaded
      wr(`SIOA_OFS_GRP_A, 32'h0000_0001);
      apply(21'h00_0001, ALL);
      chk("unloaded out", 32'(outc), 32'h0000_0000);
      wr(`SIOA_OFS_CONTROL, 32'h0000_0001);
      rd(`SIOA_OFS_CONTROL);
      chk("loaded bit", rv, 32'h0000_0001);
      apply(21'h00_0001, ALL);
      chk("loaded out", 32'(outc), 32'h0000_0001);
      wr(`SIOA_OFS_GRP_A, 32'h0000_0000);
      // each signal via its own field, codes 1..6
      for (int s = 0; s < 21; s++) begin
         wr(6'(FOFS[s]), 32'((s % 6 + 1) << FSH[s]));
         apply(21'(1 << s), ALL);
         chk("route", 32'(outc), 32'(1 << (s % 6)));
         apply(21'(1 << s), ALL ^ 21'(1 << s));
         chk("undetected", 32'(outc), 32'h0000_0000);
         wr(6'(FOFS[s]), 32'h0000_0000);
         apply(21'(1 << s), ALL);
         chk("digit zero", 32'(outc), 32'h0000_0000);
      end
      // two signals on circuit three
      wr(`SIOA_OFS_GRP_A, 32'h0000_0033);
      for (int k = 0; k < 4; k++) begin
         apply(21'(k), ALL);
         chk("or", 32'(outc), (k != 0) ? 32'h0000_0004 : 32'h0000_0000);
      end
      // brake output stays unrouted while circuits invert
      wr(`SIOA_OFS_GRP_A, 32'h0000_0000);
      for (int c = 0; c < 6; c++) begin
         wr(`SIOA_OFS_INV_LO, 32'((c < 4) ? (1 << (4 * c)) : 0));
         wr(`SIOA_OFS_INV_HI, 32'((c >= 4) ? (1 << (4 * (c - 4))) : 0));
         apply(21'h00_0000, 21'h00_0000);
         chk("invert", 32'(outc), 32'(1 << c));
      end
      wr(`SIOA_OFS_GRP_A, 32'h0000_0006);
      apply(21'h00_0001, ALL);
      chk("invert routed", 32'(outc), 32'h0000_0000);
      // shared input: every select, polarity and contact
      for (int v = 0; v < 16; v++) begin
         wr(`SIOA_OFS_SHARED_CFG, 32'((v >> 2) + 16 * v[1]));
         @(posedge clk);
         close <= v[0];
         repeat (3) @(posedge clk);
         #1;
         lv   = v[0] ^ v[1];
         fexp = 3'b000;
         if (v >= 4) fexp[(v >> 2) - 1] = (v < 8) ? !lv : lv;
         chk("shared", 32'({lat, dec, clr}), 32'(fexp));
      end
      // unloading darkens all, inversion too
      wr(`SIOA_OFS_CONTROL, 32'h0000_0000);
      apply(21'h00_0000, ALL);
      chk("unloaded", 32'({lat, dec, clr, outc}), 32'h0000_0000);
      summarize();
   end

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      summarize();
   end
endmodule // tb

`default_nettype wire
